// *** hdl/plft_device.sv ***
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module plft_device (
   // clock and reset
   input  wire logic                        clk_sys_in,
   input  wire logic                        rst_n_in,
   // management register port
   plft_mgmt_if.device_mp                   mgmt,
   // mac transmit stream
   input  wire logic [7:0]                  mac_tx_data_in,
   input  wire logic                        mac_tx_valid_in,
   input  wire logic                        mac_tx_last_in,
   // line receive stream and pcs status
   input  wire logic [7:0]                  line_rx_data_in,
   input  wire logic                        line_rx_valid_in,
   input  wire logic                        line_rx_last_in,
   input  wire logic [plft_pkg::STAT_W-1:0] rx_status_in,
   input  wire logic                        bad_ssd_entry_in,
   input  wire logic [1:0]                  speed_in,
   // line transmit stream
   output logic [7:0]                       line_tx_data_out,
   output logic                             line_tx_valid_out,
   output logic                             line_tx_last_out,
   output logic                             line_tx_enable_out,
   // mac receive stream
   output logic [7:0]                       mac_rx_data_out,
   output logic                             mac_rx_valid_out,
   output logic                             mac_rx_last_out,
   // analog control
   output logic                             echo_cancel_off_out,
   output logic                             power_down_out
);
   import plft_pkg::*;

   logic [15:0] basic_q, phy1_q, loop_q, chk_en_q, chk_src_q;
   logic [15:0] gen_en_q, gen_cfg_q, gen_len_q, gen_num_q;
   logic [15:0] rdata_q, rdata_d, gen_byte_q, gen_left_q, lfsr_q, chk_len_q, flen;
   logic [3:0]  gap_q;
   logic        ack_q, gen_done_q, gen_last, gen_start, gen_abort, gen_fin;
   logic        wr, rd_latch, pd, all_dig, remote, gen_act, frame_end;
   logic [9:0]  mtx, lrx, src, chk, ltx_q, mrx_q;
   logic        tx_en_q, echo_q, pd_q;
   logic [STAT_W-1:0]            stat;
   logic [7:0]                   gen_data;
   logic [31:0]                  frm_live_q, frm_snap_q;
   logic [15:0]                  err_live_q [NUM_ERR];
   logic [15:0]                  err_snap_q [NUM_ERR];
   logic [NUM_ERR-1:0]           err_ev;
   plft_gen_t                    gen_st_q;

   assign wr       = mgmt.req & mgmt.write;
   assign rd_latch = mgmt.req & ~mgmt.write & (mgmt.addr == ADDR_RXERR);
   assign pd       = basic_q[BASIC_PD_BIT];
   assign all_dig  = basic_q[BASIC_LOOP_BIT] & loop_q[LB_ALLDIG_BIT];
   assign remote   = loop_q[LB_REMOTE_BIT] & ~basic_q[BASIC_LOOP_BIT];

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         basic_q   <= BASIC_RESET;
         phy1_q    <= PHY1_RESET;
         loop_q    <= LOOP_RESET;
         chk_en_q  <= 16'h0000;
         chk_src_q <= 16'h0000;
         gen_en_q  <= 16'h0000;
         gen_cfg_q <= 16'h0000;
         gen_len_q <= GEN_LEN_RESET;
         gen_num_q <= GEN_NUM_RESET;
      end else if (wr) begin
         case (mgmt.addr)
            ADDR_BASIC:   basic_q   <= mgmt.wdata;
            ADDR_PHY1:    phy1_q    <= mgmt.wdata;
            ADDR_LOOP:    loop_q    <= mgmt.wdata;
            ADDR_CHK_EN:  chk_en_q  <= mgmt.wdata;
            ADDR_CHK_SRC: chk_src_q <= mgmt.wdata;
            ADDR_GEN_EN:  gen_en_q  <= mgmt.wdata;
            ADDR_GEN_CFG: gen_cfg_q <= mgmt.wdata;
            ADDR_GEN_LEN: gen_len_q <= mgmt.wdata;
            ADDR_GEN_NUM: gen_num_q <= mgmt.wdata;
            default: ;
         endcase
      end
   end

   always_comb begin
      rdata_d = 16'h0000;
      case (mgmt.addr)
         ADDR_BASIC:    rdata_d = basic_q;
         ADDR_PHY1:     rdata_d = phy1_q;
         ADDR_LOOP:     rdata_d = loop_q;
         ADDR_RXERR:    rdata_d = err_live_q[ERR_CRC];
         ADDR_CHK_EN:   rdata_d = chk_en_q;
         ADDR_CHK_SRC:  rdata_d = chk_src_q;
         ADDR_FRM_H:    rdata_d = frm_snap_q[31:16];
         ADDR_FRM_L:    rdata_d = frm_snap_q[15:0];
         ADDR_GEN_EN:   rdata_d = gen_en_q;
         ADDR_GEN_CFG:  rdata_d = gen_cfg_q;
         ADDR_GEN_LEN:  rdata_d = gen_len_q;
         ADDR_GEN_NUM:  rdata_d = gen_num_q;
         ADDR_GEN_DONE: rdata_d = {15'h0000, gen_done_q};
         default: begin
            if (mgmt.addr[15:4] == ADDR_ERR_PAGE && mgmt.addr[3:0] < 4'(NUM_ERR)) begin
               rdata_d = err_snap_q[mgmt.addr[3:0]];
            end
         end
      endcase
   end

   // one-cycle answer, reads and writes alike
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ack_q   <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         ack_q   <= mgmt.req;
         rdata_q <= mgmt.req ? rdata_d : rdata_q;
      end
   end
   assign mgmt.ack   = ack_q;
   assign mgmt.rdata = rdata_q;

   assign gen_start = wr & (mgmt.addr == ADDR_GEN_EN) & mgmt.wdata[0] & (gen_st_q == PLFT_G_IDLE)
                    & phy1_q[DIAG_CLK_BIT] & ~pd;
   assign gen_abort = (wr & (mgmt.addr == ADDR_GEN_EN) & ~mgmt.wdata[0])
                    | ~phy1_q[DIAG_CLK_BIT] | pd;
   assign gen_last  = (gen_st_q == PLFT_G_SEND) & (gen_byte_q >= gen_len_q);
   assign gen_data  = gen_cfg_q[0] ? 8'hFF : lfsr_q[7:0];
   assign gen_fin   = gen_last & (gen_left_q == 16'h0001) & ~gen_abort;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gen_st_q   <= PLFT_G_IDLE;
         gen_byte_q <= 16'h0000;
         gen_left_q <= 16'h0000;
         gap_q      <= 4'h0;
      end else begin
         case (gen_st_q)
            PLFT_G_IDLE: begin
               if (gen_start) begin
                  gen_st_q   <= PLFT_G_SEND;
                  gen_byte_q <= 16'h0001;
                  gen_left_q <= (gen_num_q == 16'h0000) ? 16'h0001 : gen_num_q;
               end
            end
            PLFT_G_SEND: begin
               if (gen_abort || gen_fin) begin
                  gen_st_q <= PLFT_G_IDLE;
               end else if (gen_last) begin
                  gen_st_q   <= PLFT_G_GAP;
                  gap_q      <= IFG_BYTES;
                  gen_left_q <= gen_left_q - 16'h0001;
               end else begin
                  gen_byte_q <= gen_byte_q + 16'h0001;
               end
            end
            PLFT_G_GAP: begin
               if (gen_abort) begin
                  gen_st_q <= PLFT_G_IDLE;
               end else if (gap_q == 4'h1) begin
                  gen_st_q   <= PLFT_G_SEND;
                  gen_byte_q <= 16'h0001;
               end else begin
                  gap_q <= gap_q - 4'h1;
               end
            end
            default: gen_st_q <= PLFT_G_IDLE;
         endcase
      end
   end

   // random payload steps once per sent byte
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         lfsr_q <= LFSR_SEED;
      end else if (gen_st_q == PLFT_G_SEND) begin
         lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         gen_done_q <= 1'b0;
      end else if (gen_fin) begin
         gen_done_q <= 1'b1;
      end else if (gen_start) begin
         gen_done_q <= 1'b0;
      end
   end

   assign gen_act = (gen_st_q != PLFT_G_IDLE);
   assign mtx     = {mac_tx_valid_in, mac_tx_last_in, mac_tx_data_in};
   assign lrx     = {line_rx_valid_in, line_rx_last_in, line_rx_data_in};
   assign src     = gen_act ? {gen_st_q == PLFT_G_SEND, gen_last, gen_data} : mtx;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ltx_q   <= 10'h000;
         mrx_q   <= 10'h000;
         tx_en_q <= 1'b0;
         echo_q  <= 1'b0;
         pd_q    <= 1'b0;
      end else begin
         ltx_q   <= pd ? 10'h000 : (remote ? lrx : src);
         tx_en_q <= ~pd & (remote | ~(all_dig & loop_q[LB_TXSUP_BIT]));
         mrx_q   <= (pd | (remote & loop_q[LB_MACSUP_BIT])) ? 10'h000 : (all_dig ? src : lrx);
         echo_q  <= loop_q[LB_CABLE_BIT] & ~pd;
         pd_q    <= pd;
      end
   end
   assign {line_tx_valid_out, line_tx_last_out, line_tx_data_out} = ltx_q;
   assign {mac_rx_valid_out, mac_rx_last_out, mac_rx_data_out}    = mrx_q;
   assign line_tx_enable_out  = tx_en_q;
   assign echo_cancel_off_out = echo_q;
   assign power_down_out      = pd_q;

   assign chk       = chk_src_q[0] ? mtx : lrx;
   assign stat      = chk_src_q[0] ? {STAT_W{1'b0}} : rx_status_in;
   assign frame_end = chk_en_q[0] & chk[9] & chk[8];
   assign flen      = (chk_len_q == 16'hFFFF) ? chk_len_q : chk_len_q + 16'h0001;

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chk_len_q <= 16'h0000;
      end else if (chk_en_q[0] && chk[9]) begin
         chk_len_q <= chk[8] ? 16'h0000 : flen;
      end
   end

   always_comb begin
      err_ev             = '0;
      err_ev[ERR_CRC]    = frame_end & stat[0];
      err_ev[ERR_LEN]    = frame_end & stat[1];
      err_ev[ERR_ALIGN]  = frame_end & stat[2];
      err_ev[ERR_SYM]    = frame_end & stat[3];
      err_ev[ERR_OVER]   = frame_end & (flen > MAX_FRAME);
      err_ev[ERR_UNDER]  = frame_end & (flen < MIN_FRAME);
      err_ev[ERR_ODDNIB] = frame_end & stat[4] & (speed_in == SPD_10 || speed_in == SPD_100);
      err_ev[ERR_ODDPRE] = frame_end & stat[5] & (speed_in == SPD_100);
      err_ev[ERR_NONINT] = frame_end & stat[6] & (speed_in == SPD_10);
      err_ev[ERR_FCAR]   = chk_en_q[0] & bad_ssd_entry_in;
   end

   // saturate, event in latch cycle kept
   for (genvar i = 0; i < NUM_ERR; i++) begin : g_err
      always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            err_live_q[i] <= 16'h0000;
            err_snap_q[i] <= 16'h0000;
         end else if (rd_latch) begin
            err_snap_q[i] <= err_live_q[i];
            err_live_q[i] <= {15'h0000, err_ev[i]};
         end else if (err_ev[i] && err_live_q[i] != 16'hFFFF) begin
            err_live_q[i] <= err_live_q[i] + 16'h0001;
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         frm_live_q <= 32'h0000_0000;
         frm_snap_q <= 32'h0000_0000;
      end else if (rd_latch) begin
         frm_snap_q <= frm_live_q;
         frm_live_q <= {31'h0000_0000, frame_end};
      end else if (frame_end && frm_live_q != 32'hFFFF_FFFF) begin
         frm_live_q <= frm_live_q + 32'h0000_0001;
      end
   end
endmodule

// *** hdl/plft_manager.sv ***
`timescale 1ns/1ps
// apb-facing controller that issues single register accesses to the device
module plft_manager (
   // clock and reset
   input  wire logic        clk_sys_in,
   input  wire logic        rst_n_in,
   // apb slave
   input  wire logic [7:0]  paddr_in,
   input  wire logic        psel_in,
   input  wire logic        penable_in,
   input  wire logic        pwrite_in,
   input  wire logic [31:0] pwdata_in,
   output logic [31:0]      prdata_out,
   output logic             pready_out,
   output logic             pslverr_out,
   // device register port
   plft_mgmt_if.manager_mp  mgmt
);
   import plft_pkg::*;

   logic [16:0] cmd_q;
   logic [15:0] wdata_q, rdata_q;
   logic [31:0] prdata_q;
   logic        pready_q, pslverr_q, busy_q, req_q, setup, access, go, mapped;
   plft_mgr_t   st_q;

   assign setup  = psel_in & ~penable_in;
   assign access = psel_in & penable_in & pready_q;
   assign mapped = (paddr_in == APB_CMD) | (paddr_in == APB_WDATA) | (paddr_in == APB_GO)
                 | (paddr_in == APB_STAT) | (paddr_in == APB_RDATA);
   // a go while busy is dropped; software polls busy first
   assign go     = access & pwrite_in & (paddr_in == APB_GO) & pwdata_in[0] & ~busy_q;

   // zero-wait answer, read data prepared in the setup cycle
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         pready_q  <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q  <= 32'h0000_0000;
      end else begin
         pready_q  <= setup;
         pslverr_q <= setup & ~mapped;
         if (setup && !pwrite_in) begin
            case (paddr_in)
               APB_CMD:   prdata_q <= {15'h0000, cmd_q};
               APB_WDATA: prdata_q <= {16'h0000, wdata_q};
               APB_STAT:  prdata_q <= {31'h0000_0000, busy_q};
               APB_RDATA: prdata_q <= {16'h0000, rdata_q};
               default:   prdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cmd_q   <= 17'h0_0000;
         wdata_q <= 16'h0000;
      end else if (access && pwrite_in && !busy_q) begin
         case (paddr_in)
            APB_CMD:   cmd_q   <= pwdata_in[CMD_WR_BIT:0];
            APB_WDATA: wdata_q <= pwdata_in[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         st_q    <= PLFT_M_IDLE;
         req_q   <= 1'b0;
         busy_q  <= 1'b0;
         rdata_q <= 16'h0000;
      end else begin
         case (st_q)
            PLFT_M_IDLE: begin
               if (go) begin
                  st_q   <= PLFT_M_WAIT;
                  req_q  <= 1'b1;
                  busy_q <= 1'b1;
               end
            end
            PLFT_M_WAIT: begin
               req_q <= 1'b0;
               if (mgmt.ack) begin
                  st_q    <= PLFT_M_IDLE;
                  busy_q  <= 1'b0;
                  rdata_q <= mgmt.rdata;
               end
            end
            default: st_q <= PLFT_M_IDLE;
         endcase
      end
   end

   assign mgmt.req    = req_q;
   assign mgmt.write  = cmd_q[CMD_WR_BIT];
   assign mgmt.addr   = cmd_q[15:0];
   assign mgmt.wdata  = wdata_q;
   assign prdata_out  = prdata_q;
   assign pready_out  = pready_q;
   assign pslverr_out = pslverr_q;
endmodule

// *** include/plft_mgmt_if.sv ***
`timescale 1ns/1ps
interface plft_mgmt_if;
   logic        req;
   logic        write;
   logic [15:0] addr;
   logic [15:0] wdata;
   logic [15:0] rdata;
   logic        ack;
   modport device_mp  (input req, write, addr, wdata, output rdata, ack);
   modport manager_mp (output req, write, addr, wdata, input rdata, ack);
endinterface

// *** include/plft_pkg.sv ***
package plft_pkg;
   // management register map (16-bit register addresses)
   localparam logic [15:0] ADDR_BASIC    = 16'h0000;
   localparam logic [15:0] ADDR_PHY1     = 16'h0012;
   localparam logic [15:0] ADDR_LOOP     = 16'h0013;
   localparam logic [15:0] ADDR_RXERR    = 16'h0014;
   localparam logic [15:0] ADDR_CHK_EN   = 16'h9403;
   localparam logic [15:0] ADDR_CHK_SRC  = 16'h9407;
   localparam logic [15:0] ADDR_FRM_H    = 16'h940A;
   localparam logic [15:0] ADDR_FRM_L    = 16'h940B;
   localparam logic [15:0] ADDR_GEN_EN   = 16'h9415;
   localparam logic [15:0] ADDR_GEN_CFG  = 16'h9416;
   localparam logic [15:0] ADDR_GEN_LEN  = 16'h9417;
   localparam logic [15:0] ADDR_GEN_NUM  = 16'h9418;
   localparam logic [15:0] ADDR_GEN_DONE = 16'h941E;
   localparam logic [11:0] ADDR_ERR_PAGE = 12'h942;
   // field positions
   localparam int unsigned BASIC_LOOP_BIT = 14;
   localparam int unsigned BASIC_PD_BIT   = 11;
   localparam int unsigned DIAG_CLK_BIT   = 2;
   localparam int unsigned LB_ALLDIG_BIT  = 12;
   localparam int unsigned LB_REMOTE_BIT  = 9;
   localparam int unsigned LB_MACSUP_BIT  = 8;
   localparam int unsigned LB_TXSUP_BIT   = 6;
   localparam int unsigned LB_CABLE_BIT   = 3;
   localparam int unsigned LB_LD_BIT      = 2;
   // values after reset
   localparam logic [15:0] BASIC_RESET   = 16'h0000;
   localparam logic [15:0] PHY1_RESET    = 16'h0000;
   localparam logic [15:0] LOOP_RESET    = 16'h1041;
   localparam logic [15:0] GEN_LEN_RESET = 16'h0040;
   localparam logic [15:0] GEN_NUM_RESET = 16'h0001;
   localparam logic [15:0] LFSR_SEED     = 16'hACE1;
   // frame limits and gap, in bytes
   localparam logic [15:0] MIN_FRAME = 16'h0040;
   localparam logic [15:0] MAX_FRAME = 16'h05EE;
   localparam logic [3:0]  IFG_BYTES = 4'hC;
   // checker counters
   localparam int unsigned STAT_W     = 7;
   localparam int unsigned NUM_ERR    = 10;
   localparam int unsigned ERR_CRC    = 0;
   localparam int unsigned ERR_LEN    = 1;
   localparam int unsigned ERR_ALIGN  = 2;
   localparam int unsigned ERR_SYM    = 3;
   localparam int unsigned ERR_OVER   = 4;
   localparam int unsigned ERR_UNDER  = 5;
   localparam int unsigned ERR_ODDNIB = 6;
   localparam int unsigned ERR_ODDPRE = 7;
   localparam int unsigned ERR_NONINT = 8;
   localparam int unsigned ERR_FCAR   = 9;
   localparam logic [1:0]  SPD_10     = 2'h0;
   localparam logic [1:0]  SPD_100    = 2'h1;
   // controller apb map
   localparam logic [7:0]  APB_CMD    = 8'h00;
   localparam logic [7:0]  APB_WDATA  = 8'h04;
   localparam logic [7:0]  APB_GO     = 8'h08;
   localparam logic [7:0]  APB_STAT   = 8'h0C;
   localparam logic [7:0]  APB_RDATA  = 8'h10;
   localparam int unsigned CMD_WR_BIT = 16;
   typedef enum logic [1:0] {
      PLFT_G_IDLE = 2'h0,
      PLFT_G_SEND = 2'h1,
      PLFT_G_GAP  = 2'h3
   } plft_gen_t;
   typedef enum logic [1:0] {
      PLFT_M_IDLE = 2'h0,
      PLFT_M_WAIT = 2'h1
   } plft_mgr_t;
endpackage

// *** tb/plft_mgmt_monitor.sv ***
`timescale 1ns/1ps
module plft_mgmt_monitor
   import plft_pkg::*;
(
   // clock and reset
   input wire logic        clk_sys_in,
   input wire logic        rst_n_in,
   // register port
   input wire logic        req,
   input wire logic        write,
   input wire logic [15:0] addr,
   input wire logic [15:0] wdata,
   input wire logic [15:0] rdata,
   input wire logic        ack
);
   logic [15:0] loop_q, basic_q, phy1_q;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!rst_n_in);
   // shadows of written values; only implemented bits are compared
   always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         loop_q  <= LOOP_RESET;
         basic_q <= BASIC_RESET;
         phy1_q  <= PHY1_RESET;
      end else if (req && write) begin
         if (addr == ADDR_LOOP) loop_q <= wdata;
         if (addr == ADDR_BASIC) basic_q <= wdata;
         if (addr == ADDR_PHY1) phy1_q <= wdata;
      end
   end
   sequence s_rd(logic [15:0] a);
      req && !write && addr == a;
   endsequence
   a_ack_one_later: assert property (req |=> ack)
      else $error("ack missing");
   a_ack_has_cause: assert property (ack |-> $past(req))
      else $error("ack without request");
   a_req_single: assert property (req |=> !req)
      else $error("request too long");
   a_rdata_holds: assert property (!req |=> $stable(rdata))
      else $error("read data moved");
   a_loop_readback: assert property (s_rd(ADDR_LOOP) |=>
      (rdata & 16'h134D) == (loop_q & 16'h134D)) else $error("loop readback");
   a_basic_readback: assert property (s_rd(ADDR_BASIC) |=>
      (rdata & 16'h4800) == (basic_q & 16'h4800)) else $error("basic readback");
   a_diag_readback: assert property (s_rd(ADDR_PHY1) |=>
      (rdata & 16'h0004) == (phy1_q & 16'h0004)) else $error("diag readback");
   a_unmapped_zero: assert property (s_rd(16'h9400) |=> rdata == 16'h0000)
      else $error("unmapped read");
endmodule

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
   import plft_pkg::*;
   typedef struct packed {logic [15:0] a; logic [15:0] d; logic [2:0] o;} plft_row_t;
   logic        clk_sys_in = 1'b0;
   logic        rst_n_in = 1'b0;
   logic        ps = 1'b0, pe = 1'b0, pw = 1'b0, mtx_v = 1'b0, lrx_v = 1'b0, lrx_l = 1'b0;
   logic        bss = 1'b0, mtx_l = 1'b0, prdy, pslv, err, ltx_v, ltx_l, ltx_en, mrx_v;
   logic        echo, pd, mrx_l;
   logic [7:0]  pa = 8'h00, mtx_d = 8'h00, lrx_d = 8'h00, ltx_d, mrx_d;
   logic [1:0]  spd = SPD_100;
   logic [6:0]  rxst = 7'h00;
   logic [31:0] pwd = 32'h0, prd, r;
   int          n_fail = 0, comparisons = 0, cyc = 0, n_ff = 0;
   // writes and the pins {power down, echo off, tx enable} they should give
   plft_row_t rows [12] = '{'{ADDR_BASIC, 16'h4000, 3'h0}, '{ADDR_LOOP, 16'h1001, 3'h1},
      '{ADDR_BASIC, 16'h0800, 3'h4}, '{ADDR_BASIC, 16'h0000, 3'h1},
      '{ADDR_LOOP, 16'h0008, 3'h3}, '{ADDR_PHY1, 16'h0004, 3'h3},
      '{ADDR_CHK_EN, 16'h0001, 3'h3}, '{ADDR_CHK_SRC, 16'h0000, 3'h3},
      '{ADDR_GEN_CFG, 16'h0001, 3'h3}, '{ADDR_GEN_LEN, 16'h0003, 3'h3},
      '{ADDR_GEN_NUM, 16'h0002, 3'h3}, '{ADDR_LOOP, 16'h0341, 3'h1}};
   logic [15:0] ca [12] = '{ADDR_FRM_H, ADDR_FRM_L, 16'h9420, 16'h9421, 16'h9422, 16'h9423,
      16'h9424, 16'h9425, 16'h9426, 16'h9427, 16'h9428, 16'h9429};
   logic [15:0] cv [12] = '{16'h0, 16'h4, 16'h2, 16'h1, 16'h1, 16'h1, 16'h0, 16'h4, 16'h2,
      16'h1, 16'h1, 16'h1};
   logic [15:0] ra [5] = '{ADDR_LOOP, ADDR_BASIC, ADDR_PHY1, ADDR_GEN_LEN, ADDR_GEN_NUM};
   logic [15:0] rv [5] = '{16'h1041, 16'h0, 16'h0, 16'h0040, 16'h0001};
   plft_mgmt_if mif ();
   plft_device plft_device_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .mgmt(mif),
      .mac_tx_data_in(mtx_d), .mac_tx_valid_in(mtx_v), .mac_tx_last_in(mtx_l),
      .line_rx_data_in(lrx_d), .line_rx_valid_in(lrx_v), .line_rx_last_in(lrx_l),
      .rx_status_in(rxst), .bad_ssd_entry_in(bss), .speed_in(spd),
      .line_tx_data_out(ltx_d), .line_tx_valid_out(ltx_v), .line_tx_last_out(ltx_l),
      .line_tx_enable_out(ltx_en), .mac_rx_data_out(mrx_d), .mac_rx_valid_out(mrx_v),
      .mac_rx_last_out(mrx_l), .echo_cancel_off_out(echo), .power_down_out(pd));
   plft_manager plft_manager_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .paddr_in(pa),
      .psel_in(ps), .penable_in(pe), .pwrite_in(pw), .pwdata_in(pwd), .prdata_out(prd),
      .pready_out(prdy), .pslverr_out(pslv), .mgmt(mif));
   plft_mgmt_monitor plft_mgmt_monitor_i (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in),
      .req(mif.req), .write(mif.write), .addr(mif.addr), .wdata(mif.wdata),
      .rdata(mif.rdata), .ack(mif.ack));
   always #2 clk_sys_in = ~clk_sys_in;
   // ceiling well above the run; all-ones line bytes counted for the generator
   always @(posedge clk_sys_in) begin
      cyc++;
      if (ltx_v === 1'b1 && ltx_d === 8'hFF) n_ff++;
      if (cyc == 20000) begin
         n_fail++;
         end_sim();
      end
   end
   task end_sim;
      $display("comparisons %0d errors %0d", comparisons, n_fail);
      if (n_fail == 0 && comparisons > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         n_fail++;
         $display("Error %s expected %h seen %h", nm, e, s);
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      ps <= 1'b1;
      pw <= w;
      pa <= a;
      pwd <= d;
      @(posedge clk_sys_in);
      pe <= 1'b1;
      do @(posedge clk_sys_in); while (prdy !== 1'b1);
      r = prd;
      err = pslv;
      ps <= 1'b0;
      pe <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task dev(input logic w, input logic [15:0] a, input logic [15:0] d);
      apb(1'b1, APB_CMD, {15'h0, w, a});
      apb(1'b1, APB_WDATA, {16'h0, d});
      apb(1'b1, APB_GO, 32'h1);
      do apb(1'b0, APB_STAT, 32'h0); while (r[0] !== 1'b0);
      apb(1'b0, APB_RDATA, 32'h0);
   endtask
   task rx(input logic [7:0] b, input logic [6:0] st, input logic f);
      lrx_v <= 1'b1;
      lrx_l <= 1'b1;
      lrx_d <= b;
      rxst <= st;
      @(posedge clk_sys_in);
      lrx_v <= 1'b0;
      lrx_l <= 1'b0;
      #1;
      chk("line loop", {ltx_v, ltx_l, ltx_d}, {2'h3, b});
      chk("mac forward", {mrx_v, mrx_l, mrx_d}, {f, f, b & {8{f}}});
      @(posedge clk_sys_in);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      foreach (rows[i]) begin
         dev(1'b1, rows[i].a, rows[i].d);
         dev(1'b0, rows[i].a, 16'h0);
         chk("readback", r, {16'h0, rows[i].d});
         chk("pins", {pd, echo, ltx_en}, rows[i].o);
      end
      rx(8'h3C, 7'h49, 1'b0);
      rx(8'hC3, 7'h31, 1'b0);
      dev(1'b1, ADDR_LOOP, 16'h0241);
      rx(8'h5A, 7'h02, 1'b1);
      // ten megabit frame: preamble parity ignored, nibble checks counted
      spd <= SPD_10;
      rx(8'hA5, 7'h74, 1'b1);
      bss <= 1'b1;
      @(posedge clk_sys_in);
      bss <= 1'b0;
      dev(1'b0, ADDR_RXERR, 16'h0);
      chk("crc count", r, 32'h2);
      foreach (ca[i]) begin
         dev(1'b0, ca[i], 16'h0);
         chk("latched counter", r, {16'h0, cv[i]});
      end
      dev(1'b0, ADDR_RXERR, 16'h0);
      chk("crc after latch", r, 32'h0);
      // checker fed from the mac side must ignore the rx_status_in flags
      dev(1'b1, ADDR_CHK_SRC, 16'h0001);
      rxst  <= 7'h01;
      mtx_v <= 1'b1;
      mtx_l <= 1'b1;
      @(posedge clk_sys_in);
      mtx_v <= 1'b0;
      mtx_l <= 1'b0;
      dev(1'b0, ADDR_RXERR, 16'h0);
      chk("mac source crc", r, 32'h0);
      dev(1'b0, ADDR_FRM_L, 16'h0);
      chk("mac source frames", r, 32'h1);
      // mac traffic runs meanwhile, so the generator must displace it
      dev(1'b1, ADDR_LOOP, 16'h1001);
      mtx_d <= 8'h55;
      mtx_v <= 1'b1;
      dev(1'b1, ADDR_GEN_EN, 16'h1);
      do dev(1'b0, ADDR_GEN_DONE, 16'h0); while (r[0] !== 1'b1);
      chk("generated bytes", n_ff, 32'h6);
      chk("mac source back", {ltx_v, ltx_d}, 9'h155);
      dev(1'b1, ADDR_GEN_LEN, 16'h0040);
      dev(1'b1, ADDR_GEN_EN, 16'h0);
      dev(1'b1, ADDR_GEN_EN, 16'h1);
      dev(1'b0, ADDR_GEN_DONE, 16'h0);
      chk("done cleared", r, 32'h0);
      mtx_v <= 1'b0;
      dev(1'b0, 16'h9400, 16'h0);
      chk("unmapped read", r, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      chk("apb error", {31'h0, err}, 32'h1);
      // second reset mid-run, generator still busy
      rst_n_in <= 1'b0;
      @(posedge clk_sys_in);
      rst_n_in <= 1'b1;
      @(posedge clk_sys_in);
      foreach (ra[i]) begin
         dev(1'b0, ra[i], 16'h0);
         chk("reset value", r, {16'h0, rv[i]});
      end
      chk("tx idle after reset", {31'h0, ltx_v}, 32'h0);
      end_sim();
   end
endmodule
